// >>> src/tcss_top.sv
// timer clock source selection: prescaler, select registers, tick routing
`timescale 1ns/100ps
module tcss_top #(
  parameter int NUM_ALT = 4
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [3:0] sfr_page,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  input  wire logic       ext_osc,
  input  wire logic       tmr0_pin,
  input  wire logic       tmr1_pin,
  input  wire logic       tmr0_counter_mode,
  input  wire logic       tmr1_counter_mode,
  input  wire logic [NUM_ALT-1:0] alt_clock_choice,
  output logic            tmr0_tick,
  output logic            tmr1_tick,
  output logic [NUM_ALT-1:0] lower_tick,
  output logic [NUM_ALT-1:0] upper_tick,
  output logic      [1:0] shared_prescale_code
);
  generate
    if (NUM_ALT != 4) begin : g_bad_num_alt
      $error("tcss_top: NUM_ALT must be 4 (timers 2 to 5)");
    end
  endgenerate

  logic [7:0] timer_clock_select;
  logic [3:0] timer_clock_select_ext;
  logic       hit_main;
  logic       hit_ext;

  function automatic logic addr_match(input logic [7:0] a,
                                      input logic [7:0] want);
    addr_match = (a == want);
  endfunction

  // a select bit of one means a count enable on every system clock
  function automatic logic pick_tick(input logic system_clock_sel,
                                     input logic scaled_tick);
    pick_tick = system_clock_sel ? 1'b1 : scaled_tick;
  endfunction

  // timer-local alternative source: 0 is system clock /12, 1 is ext /8
  function automatic logic alt_source(input logic choice,
                                      input logic div12_tick,
                                      input logic ext8_tick);
    alt_source = choice ? ext8_tick : div12_tick;
  endfunction

  assign hit_main = addr_match(sfr_addr,
                               tcss_pkg::TIMER_CLOCK_SELECT_ADDR);
  assign hit_ext  = addr_match(sfr_addr,
                               tcss_pkg::TIMER_CLOCK_SELECT_EXT_ADDR)
                    && (sfr_page == tcss_pkg::EXT_PAGE);
  assign sfr_hit  = hit_main || hit_ext;

  // qualified strobes, one per register and direction
  logic wr_main;
  logic wr_ext;
  logic rd_main;
  logic rd_ext;
  assign wr_main = sfr_wr && hit_main;
  assign wr_ext  = sfr_wr && hit_ext;
  assign rd_main = sfr_rd && hit_main;
  assign rd_ext  = sfr_rd && hit_ext;

  // register writes
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      timer_clock_select <= tcss_pkg::SELECT_RESET;
    end else if (wr_main) begin
      timer_clock_select <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      timer_clock_select_ext <= tcss_pkg::SELECT_EXT_RESET[3:0];
    end else if (wr_ext) begin
      timer_clock_select_ext <=
        sfr_wdata[3:0] & tcss_pkg::SELECT_EXT_WMASK[3:0];
    end
  end

  // read value, zero when nothing decodes
  logic [7:0] rd_value;
  always_comb begin
    rd_value = 8'h00;
    if (rd_main) begin
      rd_value = timer_clock_select;
    end else if (rd_ext) begin
      rd_value = {4'h0, timer_clock_select_ext};
    end
  end

  // read data from flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rd_value;
    end
  end

  // named fields of the two select registers
  logic tmr3_upper_system_clock_sel;
  logic tmr3_lower_system_clock_sel;
  logic tmr2_upper_system_clock_sel;
  logic tmr2_lower_system_clock_sel;
  logic tmr1_system_clock_sel;
  logic tmr0_system_clock_sel;
  logic tmr5_upper_system_clock_sel;
  logic tmr5_lower_system_clock_sel;
  logic tmr4_upper_system_clock_sel;
  logic tmr4_lower_system_clock_sel;
  assign tmr3_upper_system_clock_sel =
    timer_clock_select[tcss_pkg::TMR3_UPPER_BIT];
  assign tmr3_lower_system_clock_sel =
    timer_clock_select[tcss_pkg::TMR3_LOWER_BIT];
  assign tmr2_upper_system_clock_sel =
    timer_clock_select[tcss_pkg::TMR2_UPPER_BIT];
  assign tmr2_lower_system_clock_sel =
    timer_clock_select[tcss_pkg::TMR2_LOWER_BIT];
  assign tmr1_system_clock_sel =
    timer_clock_select[tcss_pkg::TMR1_BIT];
  assign tmr0_system_clock_sel =
    timer_clock_select[tcss_pkg::TMR0_BIT];
  assign tmr5_upper_system_clock_sel =
    timer_clock_select_ext[tcss_pkg::TMR5_UPPER_BIT];
  assign tmr5_lower_system_clock_sel =
    timer_clock_select_ext[tcss_pkg::TMR5_LOWER_BIT];
  assign tmr4_upper_system_clock_sel =
    timer_clock_select_ext[tcss_pkg::TMR4_UPPER_BIT];
  assign tmr4_lower_system_clock_sel =
    timer_clock_select_ext[tcss_pkg::TMR4_LOWER_BIT];

  assign shared_prescale_code = timer_clock_select[1:0];

  // external oscillator: two-flop synchroniser, then edge detect
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_rise;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_osc;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end
  assign ext_rise = ext_sync && !ext_prev;

  // timer pins: synchronise, then falling edge detect
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [1:0] pin_fall;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pin_meta <= 2'b11;
      pin_sync <= 2'b11;
      pin_prev <= 2'b11;
    end else begin
      pin_meta <= {tmr1_pin, tmr0_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  assign pin_fall = pin_prev & ~pin_sync;

  // dividers
  logic tick_12;
  logic tick_4;
  logic tick_48;
  logic tick_ext8;

  tcss_divider #(.DIV(tcss_pkg::DIV_BY_12)) u_div12 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .step    (1'b1),
    .tick    (tick_12)
  );

  tcss_divider #(.DIV(tcss_pkg::DIV_BY_4)) u_div4 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .step    (1'b1),
    .tick    (tick_4)
  );

  tcss_divider #(.DIV(tcss_pkg::DIV_BY_48)) u_div48 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .step    (1'b1),
    .tick    (tick_48)
  );

  tcss_divider #(.DIV(tcss_pkg::DIV_BY_8)) u_div_ext8 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .step    (ext_rise),
    .tick    (tick_ext8)
  );

  // shared prescaler mux
  logic prescale_tick;
  always_comb begin
    unique case (tcss_pkg::tcss_scale_t'(timer_clock_select[1:0]))
      tcss_pkg::TCSS_SCALE_12:  prescale_tick = tick_12;
      tcss_pkg::TCSS_SCALE_4:   prescale_tick = tick_4;
      tcss_pkg::TCSS_SCALE_48:  prescale_tick = tick_48;
      tcss_pkg::TCSS_SCALE_EXT: prescale_tick = tick_ext8;
    endcase
  end

  // timer 0 and 1: counter mode overrides the select bit
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tmr0_tick <= 1'b0;
    end else if (tmr0_counter_mode) begin
      tmr0_tick <= pin_fall[0];
    end else begin
      tmr0_tick <= pick_tick(tmr0_system_clock_sel, prescale_tick);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tmr1_tick <= 1'b0;
    end else if (tmr1_counter_mode) begin
      tmr1_tick <= pin_fall[1];
    end else begin
      tmr1_tick <= pick_tick(tmr1_system_clock_sel, prescale_tick);
    end
  end

  // timers 2..5: per-byte selects, index 0 is timer 2
  logic [NUM_ALT-1:0] lower_sel;
  logic [NUM_ALT-1:0] upper_sel;
  assign lower_sel = {
    tmr5_lower_system_clock_sel,
    tmr4_lower_system_clock_sel,
    tmr3_lower_system_clock_sel,
    tmr2_lower_system_clock_sel
  };
  assign upper_sel = {
    tmr5_upper_system_clock_sel,
    tmr4_upper_system_clock_sel,
    tmr3_upper_system_clock_sel,
    tmr2_upper_system_clock_sel
  };

  genvar i;
  generate
    for (i = 0; i < NUM_ALT; i++) begin : g_alt
      logic alt_tick;
      // choice 0: system clock /12, choice 1: external /8
      assign alt_tick = alt_source(alt_clock_choice[i],
                                   tick_12, tick_ext8);
      // lower half, or the whole timer outside split mode
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          lower_tick[i] <= 1'b0;
        end else begin
          lower_tick[i] <= pick_tick(lower_sel[i], alt_tick);
        end
      end
      // upper half, only used by a timer in split mode
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          upper_tick[i] <= 1'b0;
        end else begin
          upper_tick[i] <= pick_tick(upper_sel[i], alt_tick);
        end
      end
    end
  endgenerate
endmodule

// >>> src/tcss_pkg.sv
// constants shared by the timer clock source select block
package tcss_pkg;
  localparam logic [7:0] TIMER_CLOCK_SELECT_ADDR     = 8'h8e;
  localparam logic [7:0] TIMER_CLOCK_SELECT_EXT_ADDR = 8'he4;
  localparam logic [3:0] EXT_PAGE                    = 4'hf;
  localparam logic [7:0] SELECT_RESET                = 8'h00;
  localparam logic [7:0] SELECT_EXT_RESET            = 8'h00;
  localparam logic [7:0] SELECT_EXT_WMASK            = 8'h0f;
  // bit positions in timer_clock_select
  localparam int TMR3_UPPER_BIT = 7;
  localparam int TMR3_LOWER_BIT = 6;
  localparam int TMR2_UPPER_BIT = 5;
  localparam int TMR2_LOWER_BIT = 4;
  localparam int TMR1_BIT       = 3;
  localparam int TMR0_BIT       = 2;
  // bit positions in timer_clock_select_ext
  localparam int TMR5_UPPER_BIT = 3;
  localparam int TMR5_LOWER_BIT = 2;
  localparam int TMR4_UPPER_BIT = 1;
  localparam int TMR4_LOWER_BIT = 0;
  // divide ratios
  localparam int DIV_BY_12 = 12;
  localparam int DIV_BY_4  = 4;
  localparam int DIV_BY_48 = 48;
  localparam int DIV_BY_8  = 8;
  typedef enum logic [1:0] {
    TCSS_SCALE_12  = 2'b00,
    TCSS_SCALE_4   = 2'b01,
    TCSS_SCALE_48  = 2'b10,
    TCSS_SCALE_EXT = 2'b11
  } tcss_scale_t;
endpackage

// >>> src/tcss_divider.sv
// tick divider: one pulse every DIV enabled cycles
`timescale 1ns/100ps
module tcss_divider #(
  parameter int DIV = 12
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic step,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] count;

  generate
    if (DIV < 2) begin : g_bad_div
      $error("tcss_divider: DIV must be at least 2");
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count <= '0;
    end else if (step) begin
      count <= (count == LAST) ? '0 : count + W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tick <= 1'b0;
    end else begin
      tick <= step && (count == LAST);
    end
  end
endmodule

// >>> testbench/tcss_checker.sv
// port assertions for the timer clock source select block
`timescale 1ns/100ps
module tcss_checker #(
  parameter int NUM_ALT = 4
) (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic       tmr0_pin,
  input wire logic       tmr0_counter_mode,
  input wire logic       tmr0_tick,
  input wire logic [1:0] shared_prescale_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire logic [1:0] wcode = sfr_wdata[1:0];
  wire logic       wmain = sfr_wr && sfr_addr == 8'h8e;
  a_main_decode: assert property (sfr_addr == 8'h8e |-> sfr_hit)
    else $error("main register not decoded");
  a_ext_decode: assert property (sfr_addr == 8'he4 |->
    sfr_hit == (sfr_page == 4'hf)) else $error("ext page decode wrong");
  a_code_write: assert property (wmain |=>
    shared_prescale_code == $past(wcode)) else $error("code not written");
  a_code_hold: assert property (!wmain |=>
    $stable(shared_prescale_code)) else $error("code changed by itself");
  a_code_reset: assert property (disable iff (1'b0) !nrst |=>
    shared_prescale_code == 2'b00) else $error("code not reset");
  a_rdata_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data without read");
  a_ext_upper: assert property (sfr_rd && sfr_addr == 8'he4 |=>
    sfr_rdata[7:4] == 4'h0) else $error("ext upper bits not zero");
  a_count_pulse: assert property (tmr0_counter_mode[*4] ##0 tmr0_tick
    |=> !tmr0_tick) else $error("counter tick longer than one cycle");
  a_pin_tick: assert property (tmr0_counter_mode[*4] ##0 $fell(tmr0_pin)
    |-> ##[2:6] tmr0_tick) else $error("pin fall not counted");
endmodule

// >>> testbench/tcss_tick_sink.sv
// timer model: measures spacing and count of one chosen count enable
`timescale 1ns/100ps
module tcss_tick_sink (
  input wire logic       clk_sys,
  input wire logic [9:0] ticks,
  input wire logic [3:0] pick,
  output int             gap,
  output int             seen
);
  int run;
  always_ff @(posedge clk_sys) begin
    if (ticks[pick]) begin
      gap <= run + 1;
      seen <= seen + 1;
      run <= 0;
    end else begin
      run <= run + 1;
    end
  end
endmodule

// >>> testbench/testbench.sv
// register and tick spacing tests for the timer clock source select block
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic       clk_sys = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, ext_osc = 0;
  logic       tmr0_pin = 1, tmr1_pin = 1, cm0 = 0, cm1 = 0;
  logic       tmr0_tick, tmr1_tick, sfr_hit;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic [3:0] sfr_page = 0, alt = 0, pick = 0, lower_tick, upper_tick;
  logic [1:0] code;
  int         mismatches = 0, compares = 0, cycles = 0, gap, seen, s0;
  int         dv[4] = '{12, 4, 48, 80};
  int         ea[2][10] = '{'{0, 0, 1, 1, 12, 80, 1, 1, 12, 80},
                            '{0, 0, 80, 12, 1, 1, 80, 12, 1, 1}};
  always #4 clk_sys = ~clk_sys;
  // external oscillator at 10 system cycles per period
  always #40 ext_osc = ~ext_osc;
  tcss_top i_dut (.clk_sys, .nrst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sfr_hit, .ext_osc, .tmr0_pin, .tmr1_pin,
    .tmr0_counter_mode(cm0), .tmr1_counter_mode(cm1),
    .alt_clock_choice(alt), .tmr0_tick, .tmr1_tick, .lower_tick,
    .upper_tick, .shared_prescale_code(code));
  tcss_tick_sink i_sink (.clk_sys, .pick, .gap, .seen,
    .ticks({upper_tick, lower_tick, tmr1_tick, tmr0_tick}));
  task automatic acc(input logic [7:0] a, input logic [3:0] p,
                     input logic w, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_page = p;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge clk_sys);
    sfr_wr = 0;
    sfr_rd = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] p,
                    input logic [7:0] e);
    acc(a, p, 0, 8'h00);
    `CHK(sfr_rdata, e)
  endtask
  task automatic meas(input int i, input int e);
    pick = i[3:0];
    repeat (2 * e + 20) @(negedge clk_sys);
    `CHK(gap, e)
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1;
    rd(8'h8e, 4'h0, 8'h00);
    rd(8'he4, 4'hf, 8'h00);
    acc(8'he4, 4'hf, 1, 8'hff);
    rd(8'he4, 4'hf, 8'h0f);
    acc(8'he4, 4'h0, 1, 8'h00);
    rd(8'he4, 4'h0, 8'h00);
    rd(8'he4, 4'hf, 8'h0f);
    for (int c = 0; c < 4; c++) begin
      acc(8'h8e, 4'h0, 1, c[7:0]);
      meas(0, dv[c]);
      meas(1, dv[c]);
    end
    for (int k = 0; k < 2; k++) begin
      acc(8'h8e, 4'h3, 1, k ? 8'h00 : 8'hf0);
      acc(8'he4, 4'hf, 1, k ? 8'h0f : 8'h00);
      rd(8'h8e, 4'h5, k ? 8'h00 : 8'hf0);
      alt = k ? 4'h1 : 4'h8;
      for (int i = 2; i < 10; i++) begin
        meas(i, ea[k][i]);
      end
    end
    acc(8'h8e, 4'h0, 1, 8'h0c);
    meas(0, 1);
    meas(1, 1);
    cm0 = 1;
    cm1 = 1;
    for (int t = 0; t < 2; t++) begin
      pick = t[3:0];
      repeat (10) @(negedge clk_sys);
      s0 = seen;
      repeat (30) @(negedge clk_sys);
      `CHK(seen, s0)
      {tmr0_pin, tmr1_pin} = 2'b00;
      repeat (4) @(negedge clk_sys);
      {tmr0_pin, tmr1_pin} = 2'b11;
      repeat (10) @(negedge clk_sys);
      `CHK(seen, s0 + 1)
    end
    nrst = 0;
    repeat (2) @(negedge clk_sys);
    nrst = 1;
    rd(8'h8e, 4'h0, 8'h00);
    tally_and_finish;
  end
endmodule
bind tcss_top tcss_checker #(.NUM_ALT(NUM_ALT)) i_chk (.clk_sys, .nrst,
  .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
  .tmr0_pin, .tmr0_counter_mode, .tmr0_tick, .shared_prescale_code);
